// ---- inc/ifm_pkg.sv ----
package ifm_pkg;
    localparam int unsigned IFM_W = 16;
    // Register byte offsets
    localparam logic [7:0] IFM_OFS_FLAGS = 8'h00;
    localparam logic [7:0] IFM_OFS_MASK = 8'h04;
    localparam logic [7:0] IFM_OFS_SEL = 8'h08;
    // Bit positions
    localparam int unsigned IFM_B_EXT0 = 0;
    localparam int unsigned IFM_B_EXT1 = 1;
    localparam int unsigned IFM_B_EXT2 = 2;
    localparam int unsigned IFM_B_TMR0 = 3;
    localparam int unsigned IFM_B_SP0RX = 4;
    localparam int unsigned IFM_B_SP0TX = 5;
    localparam int unsigned IFM_B_DMA0 = 6;
    localparam int unsigned IFM_B_TMR1 = 7;
    localparam int unsigned IFM_B_EXT3 = 8;
    localparam int unsigned IFM_B_HOST = 9;
    localparam int unsigned IFM_B_SP1RX = 10;
    localparam int unsigned IFM_B_SP1TX = 11;
    localparam int unsigned IFM_B_DMA4 = 12;
    localparam int unsigned IFM_B_DMA5 = 13;
    // Selection field bits in the select register
    localparam int unsigned IFM_S_CH0 = 0;
    localparam int unsigned IFM_S_CH1 = 1;
    localparam int unsigned IFM_S_CH2 = 2;
    localparam int unsigned IFM_S_CH3 = 3;
    localparam int unsigned IFM_SEL_W = 4;
    // Bits 15..14 reserved
    localparam logic [15:0] IFM_IMPL = 16'h3FFF;
    localparam logic [15:0] IFM_FLAGS_RST = 16'h0000;
    localparam logic [15:0] IFM_MASK_RST = 16'h0000;
    localparam logic [3:0] IFM_SEL_RST = 4'h0;

    typedef struct packed {
        logic dma_ch5_irq;
        logic dma_ch4_irq;
        logic dma_ch3_irq;
        logic dma_ch2_irq;
        logic dma_ch1_irq;
        logic dma_ch0_irq;
        logic sp1_tx_irq;
        logic sp1_rx_irq;
        logic host_port_irq;
        logic external_irq_3;
        logic timer1_irq;
        logic sp0_tx_irq;
        logic sp0_rx_irq;
        logic timer0_irq;
        logic external_irq_2;
        logic external_irq_1;
        logic external_irq_0;
    } ifm_src_s;
endpackage

// ---- core/ifm_top.sv ----
// How it works
// [R1] Bits 15 and 14 are reserved, read zero, never set.
// [R2] Bit 13 is the DMA channel 5 flag and enable.
// [R3] Bit 12 is the DMA channel 4 flag and enable.
// [R4] Bit 11 is serial port 1 transmit or DMA channel 3 by select.
// [R5] Bit 10 is serial port 1 receive or DMA channel 2 by select.
// [R6] Bit 9 is the host port interrupt.
// [R7] Bit 8 is external interrupt 3.
// [R8] Bit 7 is timer 1 or DMA channel 1 by select.
// [R9] Bit 6 is reserved or DMA channel 0 by select.
// [R10] Bit 5 is serial port 0 transmit.
// [R11] Bit 4 is serial port 0 receive.
// [R12] Bit 3 is timer 0.
// [R13] Bits 2, 1, 0 are external interrupts 2, 1, 0.
// [R14] After reset bit 7 serves timer 1.
// [R15] After reset bits 10 and 11 serve serial port 1.
// [R16] After reset bit 6 carries no interrupt.
// [R17] Interrupt is the registered OR of flag AND enable, so it rises and falls one clock after them.
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ifm_top
    import ifm_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire ifm_src_s i_src,
    output logic o_irq
);
    logic rst_m_q;
    logic rst_n_q;
    logic [15:0] flags_q;
    logic [15:0] mask_q;
    logic [3:0] dma_priority_enable_ctrl_q;
    logic [15:0] ev;
    logic wr_en;
    logic hit;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_m_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n_q <= rst_m_q;
        end
    end

    // Event mapping onto the shared layout
    always_comb begin
        ev = 16'h0000;
        ev[IFM_B_EXT0] = i_src.external_irq_0; // [R13]
        ev[IFM_B_EXT1] = i_src.external_irq_1; // [R13]
        ev[IFM_B_EXT2] = i_src.external_irq_2; // [R13]
        ev[IFM_B_TMR0] = i_src.timer0_irq; // [R12]
        ev[IFM_B_SP0RX] = i_src.sp0_rx_irq; // [R11]
        ev[IFM_B_SP0TX] = i_src.sp0_tx_irq; // [R10]
        ev[IFM_B_DMA0] = dma_priority_enable_ctrl_q[IFM_S_CH0] & i_src.dma_ch0_irq; // [R9] [R16]
        ev[IFM_B_TMR1] = dma_priority_enable_ctrl_q[IFM_S_CH1]
            ? i_src.dma_ch1_irq : i_src.timer1_irq; // [R8] [R14]
        ev[IFM_B_EXT3] = i_src.external_irq_3; // [R7]
        ev[IFM_B_HOST] = i_src.host_port_irq; // [R6]
        ev[IFM_B_SP1RX] = dma_priority_enable_ctrl_q[IFM_S_CH2]
            ? i_src.dma_ch2_irq : i_src.sp1_rx_irq; // [R5] [R15]
        ev[IFM_B_SP1TX] = dma_priority_enable_ctrl_q[IFM_S_CH3]
            ? i_src.dma_ch3_irq : i_src.sp1_tx_irq; // [R4] [R15]
        ev[IFM_B_DMA4] = i_src.dma_ch4_irq; // [R3]
        ev[IFM_B_DMA5] = i_src.dma_ch5_irq; // [R2]
    end

    assign wr_en = i_psel & i_penable & i_pwrite;
    assign hit = (i_paddr == IFM_OFS_FLAGS) | (i_paddr == IFM_OFS_MASK)
        | (i_paddr == IFM_OFS_SEL);

    // Sticky flags, write one to clear; a new event wins
    always_ff @(posedge i_mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            flags_q <= IFM_FLAGS_RST;
        end else begin
            if (wr_en && i_paddr == IFM_OFS_FLAGS) begin
                flags_q <= ((flags_q & ~i_pwdata[15:0]) | ev) & IFM_IMPL; // [R1]
            end else begin
                flags_q <= (flags_q | ev) & IFM_IMPL; // [R1]
            end
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mask_q <= IFM_MASK_RST;
        end else if (wr_en && i_paddr == IFM_OFS_MASK) begin
            mask_q <= i_pwdata[15:0] & IFM_IMPL; // [R1]
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            dma_priority_enable_ctrl_q <= IFM_SEL_RST; // [R14] [R15] [R16]
        end else if (wr_en && i_paddr == IFM_OFS_SEL) begin
            dma_priority_enable_ctrl_q <= i_pwdata[IFM_SEL_W-1:0];
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (i_paddr == IFM_OFS_FLAGS) begin
            rdata_d[15:0] = flags_q;
        end else if (i_paddr == IFM_OFS_MASK) begin
            rdata_d[15:0] = mask_q;
        end else if (i_paddr == IFM_OFS_SEL) begin
            rdata_d[IFM_SEL_W-1:0] = dma_priority_enable_ctrl_q;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 32'h0000_0000;
        end else if (i_psel && !i_penable) begin
            rdata_q <= rdata_d;
        end
    end

    assign o_prdata = rdata_q;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~hit;

    always_ff @(posedge i_mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(flags_q & mask_q); // [R17]
        end
    end
endmodule // ifm_top
`default_nettype wire

// ---- tb/ifm_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module ifm_checker
    import ifm_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire ifm_src_s i_src,
    input wire logic o_irq
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    logic [15:0] m_q;
    logic [3:0] s_q;
    wire logic [16:0] s = i_src;
    wire logic wr = i_psel && i_penable && i_pwrite;
    // Mirror of mask and select as software wrote them
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) {m_q, s_q} <= 20'h00000;
        else if (wr && i_paddr == 8'h04) m_q <= i_pwdata[15:0];
        else if (wr && i_paddr == 8'h08) s_q <= i_pwdata[3:0];
    end
    chk_res_zero: assert property (i_psel && i_penable && i_paddr <= 8'h08 |-> o_prdata[31:14] == 0)
        else $error("reserved bits read");
    chk_mask_quiet: assert property (m_q == 0 && $past(m_q) == 0 |-> !o_irq)
        else $error("irq while masked");
    chk_ext0_rise: assert property (m_q[0] && s[0] ##1 m_q[0] |-> ##1 o_irq)
        else $error("ext0 no irq");
    chk_host_rise: assert property (m_q[9] && s[8] ##1 m_q[9] |-> ##1 o_irq)
        else $error("host no irq");
    chk_dma5_rise: assert property (m_q[13] && s[16] ##1 m_q[13] |-> ##1 o_irq)
        else $error("dma5 no irq");
    chk_tmr1_dflt: assert property (m_q[7] && !s_q[1] && s[6] ##1 m_q[7] |-> ##1 o_irq)
        else $error("timer1 no irq");
    chk_dma1_sel: assert property (m_q[7] && s_q[1] && s[12] ##1 m_q[7] |-> ##1 o_irq)
        else $error("dma1 no irq");
    chk_sp1_dflt: assert property (m_q[10] && !s_q[2] && s[9] ##1 m_q[10] |-> ##1 o_irq)
        else $error("sp1 rx no irq");
endmodule // ifm_checker
bind ifm_top ifm_checker u_chk (.*);
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ifm_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, irq, rdy, err, e;
    logic [7:0] addr = 8'h00;
    logic [31:0] wd = 32'h0, rd, got;
    ifm_src_s src = '0;
    int n_mismatch = 0, samples_checked = 0, p;
    int p0[17] = '{0, 1, 2, 3, 4, 5, 7, 8, 9, 10, 11, 99, 99, 99, 99, 12, 13};
    int p1[17] = '{0, 1, 2, 3, 4, 5, 99, 8, 9, 99, 99, 6, 7, 10, 11, 12, 13};
    always #2 clk = ~clk;
    ifm_top dut (.i_mclk(clk), .i_arst_n(rst_n), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .o_prdata(rd), .o_pready(rdy),
        .o_pslverr(err), .i_src(src), .o_irq(irq));
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pen, pwr, addr, wd} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        got = rd;
        e = err;
        {psel, pen} <= 2'b00;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        chk(got, x);
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        src <= ifm_src_s'(17'h1 << i);
        @(posedge clk);
        src <= '0;
    endtask
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rdc(8'h00, 32'h0);
        rdc(8'h04, 32'h0);
        rdc(8'h08, 32'h0);
        rdc(8'h0C, 32'h0);
        chk(e, 1'b1);
        xfer(1'b1, 8'h04, 32'hFFFF);
        rdc(8'h04, 32'h3FFF);
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 17; i++) begin
                pulse(i);
                p = k ? p1[i] : p0[i];
                rdc(8'h00, p > 15 ? 32'h0 : 32'h1 << p);
                chk(irq, p < 16);
                xfer(1'b1, 8'h00, 32'hFFFF);
            end
            xfer(1'b1, 8'h08, 32'hF);
        end
        rdc(8'h08, 32'hF);
        xfer(1'b1, 8'h04, 32'h0);
        pulse(8);
        rdc(8'h00, 32'h200);
        chk(irq, 1'b0);
        xfer(1'b1, 8'h04, 32'h200);
        rdc(8'h04, 32'h200);
        chk(irq, 1'b1);
        tally_and_finish;
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        tally_and_finish;
    end
endmodule // tb_top
`default_nettype wire
